//--- rtl/pbmr_pkg.sv
package pbmr_pkg;
   localparam int ADDR_W = 12;
   // byte address = 4 * register index
   localparam logic [9:0] IDX_CONTROL = 10'h000;
   localparam logic [9:0] IDX_STATUS = 10'h001;
   localparam logic [9:0] IDX_ID_HIGH = 10'h002;
   localparam logic [9:0] IDX_ID_LOW = 10'h003;
   localparam logic [9:0] IDX_IND_CTL = 10'h00d;
   localparam logic [9:0] IDX_IND_VAL = 10'h00e;
   localparam logic [9:0] IDX_XCVR_CTL = 10'h010;
   localparam logic [9:0] IDX_XCVR_SETUP = 10'h011;
   localparam logic [9:0] IDX_FLAGS_A = 10'h012;
   localparam logic [9:0] IDX_FLAGS_B = 10'h013;
   localparam logic [9:0] IDX_LOOP_SETUP = 10'h016;
   localparam logic [9:0] IDX_FLAGS_C = 10'h018;
   localparam logic [9:0] IDX_CABLE_TEST = 10'h01e;
   localparam logic [9:0] IDX_CHIP_RESET = 10'h01f;
   localparam logic [9:0] IDX_RX_STATE = 10'h180;
   // control register fields
   localparam int CTL_RESET_BIT = 15;
   localparam int CTL_LOOP_BIT = 14;
   localparam int CTL_SPEED_LSB_BIT = 13;
   localparam int CTL_PDOWN_BIT = 11;
   localparam int CTL_ISOLATE_BIT = 10;
   localparam int CTL_DUPLEX_BIT = 8;
   localparam int CTL_SPEED_MSB_BIT = 6;
   localparam logic [15:0] CTL_RESET_VAL = 16'h0140;
   localparam logic [1:0] SPEED_1000 = 2'h2;
   localparam logic DUPLEX_FULL = 1'b1;
   // status register: write-zero-clear bits 4 and 1, write-zero-set bit 2
   localparam logic [15:0] STAT_FIXED = 16'h0141;
   localparam int STAT_ZCLR_HI_BIT = 4;
   localparam int STAT_LINK_BIT = 2;
   localparam int STAT_ZCLR_LO_BIT = 1;
   // identity values are arbitrary
   localparam logic [15:0] ID_HIGH_VAL = 16'h1234;
   localparam logic [15:0] ID_LOW_VAL = 16'h5670;
   // soft reset duration, in cycles
   localparam int RST_NS = 200;
   localparam int CLK_NS = 25;
   localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] RST_CYC_W = 4'(RST_CYC);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pbmr_pkg

//--- rtl/pbmr_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - decode base offsets 0x0..0x1F plus receiver status at 0x180.
// - control bit 15 resets digital logic and registers 0x0..0xF to default.
// - control bit 14 enables MAC-side loopback.
// - bit 11 power down (also by pin), bit 10 isolate.
// - speed bits 6 (msb) and 13 (lsb) read-only, report 1000 Mb/s.
// - bit 8 reads 1, full duplex, read-only.
// - control resets to 0x140, reserved bits read zero.
// - write-zero-clear, write-zero-set and self-clearing bit types supported.
// - manual-clear bit holds until its clearing event, then default.
module pbmr_regs (
   input wire logic mclk_i, // 40 MHz clock
   input wire logic nrst_i, // sync reset, active low
   input wire logic [pbmr_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [pbmr_pkg::ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready, // read ready
   input wire logic pdown_pin_i, // power-down request pin, high active
   input wire logic link_up_i, // current link state
   output logic loopback_o, // mac-side loopback enable
   output logic power_down_o, // power down, register or pin
   output logic isolate_o, // isolate mode
   output logic digital_rst_o // digital logic held in reset
);
   import pbmr_pkg::*;

   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic loop_en;
   logic pdown_en;
   logic isolate_en;
   logic soft_rst;
   logic [3:0] rst_cnt;
   logic link_latch;
   logic zclr_hi;
   logic zclr_lo;
   logic [15:0] ctl_word;
   logic [15:0] stat_word;
   logic [15:0] rd_word;

   // write channels taken independently, one write outstanding
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire have_aw = aw_held || aw_take;
   wire have_w = w_held || w_take;
   wire [ADDR_W-1:0] wa = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wd = w_held ? w_data : s_axi_wdata;
   wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
   wire do_write = have_aw && have_w && !s_axi_bvalid;
   wire [9:0] widx = wa[11:2];
   wire [9:0] ridx = s_axi_araddr[11:2];
   wire lo_en = ws[0];
   wire hi_en = ws[1];
   wire wr_ctl = do_write && widx == IDX_CONTROL;
   wire wr_stat = do_write && widx == IDX_STATUS;

   // reserved offsets are not written; they only answer with an error
   wire ridx_known = ridx == IDX_CONTROL || ridx == IDX_STATUS || ridx == IDX_ID_HIGH || ridx == IDX_ID_LOW ||
      ridx == IDX_IND_CTL || ridx == IDX_IND_VAL || ridx == IDX_XCVR_CTL || ridx == IDX_XCVR_SETUP ||
      ridx == IDX_FLAGS_A || ridx == IDX_FLAGS_B || ridx == IDX_LOOP_SETUP || ridx == IDX_FLAGS_C ||
      ridx == IDX_CABLE_TEST || ridx == IDX_CHIP_RESET || ridx == IDX_RX_STATE;
   wire widx_known = widx == IDX_CONTROL || widx == IDX_STATUS || widx == IDX_ID_HIGH || widx == IDX_ID_LOW ||
      widx == IDX_IND_CTL || widx == IDX_IND_VAL || widx == IDX_XCVR_CTL || widx == IDX_XCVR_SETUP ||
      widx == IDX_FLAGS_A || widx == IDX_FLAGS_B || widx == IDX_LOOP_SETUP || widx == IDX_FLAGS_C ||
      widx == IDX_CABLE_TEST || widx == IDX_CHIP_RESET || widx == IDX_RX_STATE;

   wire start_soft_rst = wr_ctl && hi_en && wd[CTL_RESET_BIT] && !soft_rst;
   wire soft_done = soft_rst && rst_cnt == 4'h0;
   wire regs_clr = !nrst_i || soft_rst;

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (aw_take && !do_write) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (w_take && !do_write) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= widx_known ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // manual-clear reset bit: held until the count runs out, then back to 0
   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         soft_rst <= 1'b0;
         rst_cnt <= 4'h0;
      end else if (start_soft_rst) begin
         soft_rst <= 1'b1;
         rst_cnt <= RST_CYC_W - 4'h1;
      end else if (soft_done) begin
         soft_rst <= 1'b0;
      end else if (soft_rst) begin
         rst_cnt <= rst_cnt - 4'h1;
      end
   end

   // writable control fields; read-only fields take no write
   always_ff @(posedge mclk_i) begin
      if (regs_clr) begin
         loop_en <= CTL_RESET_VAL[CTL_LOOP_BIT];
         pdown_en <= CTL_RESET_VAL[CTL_PDOWN_BIT];
         isolate_en <= CTL_RESET_VAL[CTL_ISOLATE_BIT];
      end else if (wr_ctl && hi_en) begin
         loop_en <= wd[CTL_LOOP_BIT];
         pdown_en <= wd[CTL_PDOWN_BIT];
         isolate_en <= wd[CTL_ISOLATE_BIT];
      end
   end

   // latch-low link bit: a link drop clears it, writing 0 sets it again
   // nothing here sets the write-zero-clear bits, so they read 0 until a source is wired in
   always_ff @(posedge mclk_i) begin
      if (regs_clr) begin
         link_latch <= 1'b0;
         zclr_hi <= 1'b0;
         zclr_lo <= 1'b0;
      end else begin
         if (!link_up_i) begin
            link_latch <= 1'b0;
         end else if (wr_stat && lo_en && !wd[STAT_LINK_BIT]) begin
            link_latch <= 1'b1;
         end
         if (wr_stat && lo_en && !wd[STAT_ZCLR_HI_BIT]) begin
            zclr_hi <= 1'b0;
         end
         if (wr_stat && lo_en && !wd[STAT_ZCLR_LO_BIT]) begin
            zclr_lo <= 1'b0;
         end
      end
   end

   always_comb begin
      ctl_word = 16'h0000;
      ctl_word[CTL_RESET_BIT] = soft_rst;
      ctl_word[CTL_LOOP_BIT] = loop_en;
      ctl_word[CTL_SPEED_MSB_BIT] = SPEED_1000[1];
      ctl_word[CTL_SPEED_LSB_BIT] = SPEED_1000[0];
      ctl_word[CTL_PDOWN_BIT] = pdown_en;
      ctl_word[CTL_ISOLATE_BIT] = isolate_en;
      ctl_word[CTL_DUPLEX_BIT] = DUPLEX_FULL;
   end

   always_comb begin
      stat_word = STAT_FIXED;
      stat_word[STAT_ZCLR_HI_BIT] = zclr_hi;
      stat_word[STAT_LINK_BIT] = link_latch;
      stat_word[STAT_ZCLR_LO_BIT] = zclr_lo;
   end

   // other listed offsets hold no fields in this block and read zero
   assign rd_word = ridx == IDX_CONTROL ? ctl_word :
      ridx == IDX_STATUS ? stat_word :
      ridx == IDX_ID_HIGH ? ID_HIGH_VAL :
      ridx == IDX_ID_LOW ? ID_LOW_VAL : 16'h0000;

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_word};
         s_axi_rresp <= ridx_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!nrst_i) begin
         loopback_o <= 1'b0;
         power_down_o <= 1'b0;
         isolate_o <= 1'b0;
         digital_rst_o <= 1'b0;
      end else begin
         loopback_o <= loop_en;
         power_down_o <= pdown_en || pdown_pin_i;
         isolate_o <= isolate_en;
         digital_rst_o <= soft_rst;
      end
   end

   ctl_reset_val_a: assert property (@(posedge mclk_i) $rose(nrst_i) |-> ctl_word == CTL_RESET_VAL)
      else $error("control word not at reset value");
   speed_duplex_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      ctl_word[CTL_SPEED_LSB_BIT] == 1'b0 && ctl_word[CTL_SPEED_MSB_BIT] == 1'b1 && ctl_word[CTL_DUPLEX_BIT] == 1'b1)
      else $error("speed or duplex bits wrong");
   reserved_zero_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (ctl_word & 16'h12bf) == 16'h0000)
      else $error("reserved control bits nonzero");
   // soft reset sequencing
   soft_rst_start_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      start_soft_rst |=> soft_rst && rst_cnt == RST_CYC_W - 4'h1)
      else $error("soft reset did not start");
   soft_rst_busy_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      soft_rst && rst_cnt != 4'h0 |=> soft_rst)
      else $error("soft reset ended early");
   soft_rst_len_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $rose(soft_rst) |-> soft_rst [*8] ##1 !soft_rst)
      else $error("soft reset length wrong");
   soft_rst_end_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      soft_done |=> !soft_rst)
      else $error("soft reset bit not cleared");
   soft_rst_clear_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      soft_rst |=> !loop_en && !pdown_en && !isolate_en)
      else $error("control fields not cleared by soft reset");
   status_clear_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      soft_rst |=> !link_latch && !zclr_hi && !zclr_lo)
      else $error("status bits not cleared by soft reset");
   digital_rst_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      soft_rst |=> digital_rst_o)
      else $error("digital reset output not raised");
   // control fields and outputs
   loop_follow_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      wr_ctl && hi_en && !soft_rst && !wd[CTL_RESET_BIT] |=>
      loop_en == $past(wd[CTL_LOOP_BIT]) ##1 loopback_o == $past(wd[CTL_LOOP_BIT], 2))
      else $error("loopback does not follow write");
   loop_keep_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      wr_ctl && !hi_en && !soft_rst |=> loop_en == $past(loop_en))
      else $error("loopback changed without its byte");
   field_write_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      wr_ctl && hi_en && !soft_rst |=>
      pdown_en == $past(wd[CTL_PDOWN_BIT]) && isolate_en == $past(wd[CTL_ISOLATE_BIT]))
      else $error("power down or isolate does not follow write");
   pdown_pin_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      pdown_pin_i |=> power_down_o)
      else $error("pin power down ignored");
   pdown_reg_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      pdown_en |=> power_down_o)
      else $error("register power down ignored");
   isolate_out_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      1'b1 |=> isolate_o == $past(isolate_en))
      else $error("isolate output does not follow field");
   // status latch
   link_set_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      wr_stat && lo_en && !wd[STAT_LINK_BIT] && link_up_i && !soft_rst |=> link_latch)
      else $error("write zero did not set link bit");
   link_drop_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !link_up_i |=> !link_latch)
      else $error("link drop did not clear link bit");
   link_keep_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      link_latch && link_up_i && !soft_rst |=> link_latch)
      else $error("link bit lost while link up");
   // bus answers
   known_write_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      do_write && widx_known |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
      else $error("listed write not answered okay");
   known_read_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      s_axi_arvalid && s_axi_arready && ridx_known |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY)
      else $error("listed read not answered okay");
   listed_zero_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      s_axi_arvalid && s_axi_arready && ridx_known && ridx != IDX_CONTROL && ridx != IDX_STATUS &&
      ridx != IDX_ID_HIGH && ridx != IDX_ID_LOW |=> s_axi_rdata == 32'h0000_0000)
      else $error("fieldless listed read not zero");
   ctl_read_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      s_axi_arvalid && s_axi_arready && ridx == IDX_CONTROL |=> s_axi_rdata[CTL_RESET_BIT] == $past(soft_rst))
      else $error("reset bit read wrong");
   unmapped_read_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      s_axi_arvalid && s_axi_arready && !ridx_known |=> s_axi_rdata == 32'h0 && s_axi_rresp == RESP_SLVERR)
      else $error("unmapped read not zero");
endmodule : pbmr_regs

//--- testbench/pbmr_host.sv
`timescale 1ns/1ps
module pbmr_host (
   input wire logic mclk_i, // register clock
   output logic [11:0] s_axi_awaddr, // write address
   output logic s_axi_awvalid, // write address valid
   input wire logic s_axi_awready, // write address ready
   output logic [31:0] s_axi_wdata, // write data
   output logic [3:0] s_axi_wstrb, // byte strobes
   output logic s_axi_wvalid, // write data valid
   input wire logic s_axi_wready, // write data ready
   input wire logic [1:0] s_axi_bresp, // write response
   input wire logic s_axi_bvalid, // write response valid
   output logic s_axi_bready, // write response ready
   output logic [11:0] s_axi_araddr, // read address
   output logic s_axi_arvalid, // read address valid
   input wire logic s_axi_arready, // read address ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic [1:0] s_axi_rresp, // read response
   input wire logic s_axi_rvalid, // read valid
   output logic s_axi_rready // read ready
);
   initial begin
      s_axi_awaddr = 12'h000;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 12'h000;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
   end

   // call at a rising edge; both channels offered together, each dropped when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // spare edge so a following call never reassigns bready in this step
      @(posedge mclk_i);
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge mclk_i);
   endtask : rd
endmodule : pbmr_host

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
   import pbmr_pkg::*;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic pdown_pin_i = 1'b0;
   logic link_up_i = 1'b0;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic loopback_o, power_down_o, isolate_o, digital_rst_o;
   int miscompares = 0;
   int check_count = 0;

   always #12.5 mclk_i = ~mclk_i;

   pbmr_regs dut (.*);
   pbmr_host host (.*);

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
      host.rd({idx, 2'b00}, rd_data, resp);
      chk(rd_data, exp);
      chk({30'h0, resp}, {30'h0, er});
   endtask : rdchk

   task automatic wrchk(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] s);
      host.wr({idx, 2'b00}, d, s, resp);
      chk({30'h0, resp}, {30'h0, RESP_OKAY});
   endtask : wrchk

   task automatic outs(input logic [3:0] exp);
      repeat (2) @(posedge mclk_i);
      chk({28'h0, loopback_o, power_down_o, isolate_o, digital_rst_o}, {28'h0, exp});
   endtask : outs

   task automatic t_reset_vals;
      rdchk(IDX_CONTROL, 32'h0000_0140, RESP_OKAY);
      outs(4'h0);
      rdchk(IDX_ID_HIGH, {16'h0000, ID_HIGH_VAL}, RESP_OKAY);
   endtask : t_reset_vals

   task automatic t_control;
      // read-only speed, duplex and reserved bits must not move
      wrchk(IDX_CONTROL, 32'hffff_7fff, 4'hf);
      rdchk(IDX_CONTROL, 32'h0000_4d40, RESP_OKAY);
      outs(4'he);
      wrchk(IDX_CONTROL, 32'h0000_0000, 4'hf);
      rdchk(IDX_CONTROL, 32'h0000_0140, RESP_OKAY);
      outs(4'h0);
   endtask : t_control

   task automatic t_pin;
      pdown_pin_i <= 1'b1;
      outs(4'h4);
      rdchk(IDX_CONTROL, 32'h0000_0140, RESP_OKAY);
      pdown_pin_i <= 1'b0;
      outs(4'h0);
   endtask : t_pin

   task automatic t_soft_reset;
      wrchk(IDX_CONTROL, 32'h0000_4000, 4'h3);
      // loopback set in the same write, so only the soft reset can clear it
      wrchk(IDX_CONTROL, 32'h0000_c000, 4'h3);
      rdchk(IDX_CONTROL, 32'h0000_8140, RESP_OKAY);
      chk({31'h0, digital_rst_o}, 32'h1);
      repeat (12) @(posedge mclk_i);
      rdchk(IDX_CONTROL, 32'h0000_0140, RESP_OKAY);
      outs(4'h0);
   endtask : t_soft_reset

   task automatic t_status;
      link_up_i <= 1'b1;
      rdchk(IDX_STATUS, {16'h0000, STAT_FIXED}, RESP_OKAY);
      wrchk(IDX_STATUS, 32'h0000_ffff, 4'h1);
      rdchk(IDX_STATUS, 32'h0000_0141, RESP_OKAY);
      wrchk(IDX_STATUS, 32'h0000_0000, 4'h1);
      rdchk(IDX_STATUS, 32'h0000_0145, RESP_OKAY);
      link_up_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      link_up_i <= 1'b1;
      rdchk(IDX_STATUS, 32'h0000_0141, RESP_OKAY);
   endtask : t_status

   task automatic t_decode;
      rdchk(IDX_IND_CTL, 32'h0, RESP_OKAY);
      rdchk(IDX_IND_VAL, 32'h0, RESP_OKAY);
      rdchk(IDX_XCVR_CTL, 32'h0, RESP_OKAY);
      rdchk(IDX_XCVR_SETUP, 32'h0, RESP_OKAY);
      rdchk(IDX_FLAGS_A, 32'h0, RESP_OKAY);
      rdchk(IDX_FLAGS_B, 32'h0, RESP_OKAY);
      rdchk(IDX_LOOP_SETUP, 32'h0, RESP_OKAY);
      rdchk(IDX_FLAGS_C, 32'h0, RESP_OKAY);
      rdchk(IDX_CABLE_TEST, 32'h0, RESP_OKAY);
      rdchk(IDX_CHIP_RESET, 32'h0, RESP_OKAY);
      rdchk(IDX_RX_STATE, 32'h0, RESP_OKAY);
      // reserved places are only read, never written
      rdchk(10'h004, 32'h0, RESP_SLVERR);
      rdchk(10'h181, 32'h0, RESP_SLVERR);
      wrchk(IDX_ID_LOW, 32'h0000_0000, 4'hf);
      rdchk(IDX_ID_LOW, {16'h0000, ID_LOW_VAL}, RESP_OKAY);
   endtask : t_decode

   task automatic final_report;
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (20) @(posedge mclk_i);
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      t_reset_vals();
      t_control();
      t_pin();
      t_soft_reset();
      t_status();
      t_decode();
      final_report();
   end

   // whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge mclk_i);
      miscompares++;
      final_report();
   end
endmodule : tb
